// ===== hdl/bih_pkg.sv
package bih_pkg;

   localparam int NSRC     = 40;
   localparam int LW       = 3;
   localparam int VW       = 8;
   localparam int SIW      = 6;
   localparam int NBUSIRQ  = 7;
   localparam int NTMR     = 3;
   localparam int NMBX     = 8;
   localparam int MSW      = 3;
   localparam int NLOC     = 17;
   localparam int NLVL     = 8;

   // source numbering, also the fixed increment added to the vector base
   localparam int SRC_BUS   = 0;
   localparam int SRC_EXP   = 7;
   localparam int SRC_SER   = 8;
   localparam int SRC_CAL   = 9;
   localparam int SRC_TMR   = 10;
   localparam int SRC_PFAIL = 13;
   localparam int SRC_SFAIL = 14;
   localparam int SRC_MBX   = 15;
   localparam int SRC_LOC   = 23;

   localparam int TW_WIDE   = 24;
   localparam int PW_WIDE   = 5;
   localparam int TW_WDOG   = 8;
   localparam int PW_WDOG   = 4;

   localparam logic [LW-1:0] LVL_OFF = 3'h0;
   localparam logic [VW-1:0] VEC_RST = 8'h00;

   // synchronised pin bundle layout
   localparam int SY_WDATA = 0;
   localparam int SY_SEL   = 8;
   localparam int SY_WR    = 11;
   localparam int SY_LOCK  = 12;
   localparam int SY_REQ   = 13;
   localparam int SY_LOC   = 14;
   localparam int SY_SFAIL = 31;
   localparam int SY_PFAIL = 32;
   localparam int SY_CAL   = 33;
   localparam int SY_SER   = 34;
   localparam int SY_EXP   = 35;
   localparam int SY_BUS   = 36;
   localparam int SYW      = 43;

   typedef enum logic [1:0] {VS_OWN, VS_PERIPH, VS_BUS} bih_vsrc_type;

   // where the vector of a source comes from during acknowledge
   function automatic bih_vsrc_type bih_vsrc_of(input logic [SIW-1:0] idx);
      if (idx <= 6'(SRC_EXP))
         return VS_BUS;
      else if (idx == 6'(SRC_SER) || idx >= 6'(SRC_LOC))
         return VS_PERIPH;
      else
         return VS_OWN;
   endfunction

   function automatic logic bih_is_mbx(input logic [SIW-1:0] idx);
      return (idx >= 6'(SRC_MBX)) && (idx < 6'(SRC_LOC));
   endfunction

endpackage

// ===== hdl/bih_timer.sv
module bih_timer
   import bih_pkg::*;
#(
   parameter int W  = TW_WIDE,
   parameter int PW = PW_WIDE
)(
   input  wire logic          i_clk,
   input  wire logic          i_nrst,
   input  wire logic          i_en,
   input  wire logic          i_wdog,
   input  wire logic          i_restart,
   input  wire logic [W-1:0]  i_reload,
   input  wire logic [PW-1:0] i_pre,
   output logic               o_expire,
   output logic               o_fail
);

   logic [PW-1:0] pre_ff;
   logic [W-1:0]  cnt_ff;
   logic          expire_ff;
   logic          fail_ff;

   wire tick    = i_en && !fail_ff && (pre_ff == i_pre);
   wire at_zero = (cnt_ff == '0);
   wire fire    = tick && at_zero;

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         pre_ff    <= '0;
         cnt_ff    <= '0;
         expire_ff <= 1'b0;
         fail_ff   <= 1'b0;
      end
      else
      begin
         pre_ff    <= (tick || i_restart || !i_en) ? '0 : PW'(pre_ff + 1'b1);
         if (i_restart || fire)
            cnt_ff <= i_reload;
         else if (tick)
            cnt_ff <= W'(cnt_ff - 1'b1);
         expire_ff <= fire;
         // missed restart latches
         // an expiry that meets a restart still latches: set wins
         if (fire && i_wdog)
            fail_ff <= 1'b1;
         else if (i_restart || !i_wdog)
            fail_ff <= 1'b0;
      end
   end

   assign o_expire = expire_ff;
   assign o_fail   = fail_ff;

   expire_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (tick && at_zero && !i_restart) |=> (o_expire && cnt_ff == $past(i_reload)))
      else $error("timer did not expire and reload at zero");
   wdog_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (o_fail && !i_restart && i_wdog) |=> o_fail)
      else $error("watchdog fail dropped without restart");

endmodule

// ===== hdl/bih_prio.sv
module bih_prio
   import bih_pkg::*;
#(
   parameter int N = NSRC
)(
   input  wire logic [N-1:0]    i_pend,
   input  wire logic [N*LW-1:0] i_level,
   input  wire logic [LW-1:0]   i_qlvl,
   output logic [LW-1:0]        o_max_lvl,
   output logic                 o_hit,
   output logic [SIW-1:0]       o_idx
);

   // scan downward so the lowest numbered source at the asked level wins
   always_comb
   begin
      o_max_lvl = LVL_OFF;
      o_hit     = 1'b0;
      o_idx     = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (i_pend[i] && i_level[i*LW +: LW] > o_max_lvl)
            o_max_lvl = i_level[i*LW +: LW];
         if (i_pend[i] && i_level[i*LW +: LW] == i_qlvl && i_qlvl != LVL_OFF)
         begin
            o_hit = 1'b1;
            o_idx = SIW'(i);
         end
      end
   end

endmodule

// ===== hdl/bih_hub.sv
// Overview of operation
// - each source gets its own level 1-7
// - merge local, timer and bus requests
// - acknowledge supplies or fetches the vector
// - power-fail and system-fail are sources
// - forty sources, each with a level
// - own vectors are base plus index, except mailboxes
// - eight mailboxes; bus access raises interrupt
// - per-level vector for mailbox interrupts
// - locked read-modify-write mailbox access honoured
// - each timer interrupts at own level
// - two 24-bit timers, 5-bit prescalers
// - 8-bit timer with divider drives fail
// - missed watchdog restart of the 8-bit timer asserts system-fail
// - each timer watchdog or periodic
module bih_hub
   import bih_pkg::*;
#(
   parameter logic [VW-1:0] SPUR_VEC = 8'h0f
)(
   input  wire logic                  i_clk,
   input  wire logic                  i_nrst,
   input  wire logic [NBUSIRQ-1:0]    i_bus_irq,
   input  wire logic                  i_exp_irq,
   input  wire logic                  i_ser_irq,
   input  wire logic                  i_cal_irq,
   input  wire logic                  i_pfail,
   input  wire logic                  i_sfail_in,
   input  wire logic [NLOC-1:0]       i_loc_irq,
   input  wire logic [NSRC*LW-1:0]    i_src_level,
   input  wire logic [VW-1:0]         i_vec_base,
   input  wire logic [NLVL*VW-1:0]    i_lvl_vec,
   input  wire logic [NTMR-1:0]       i_tmr_en,
   input  wire logic [NTMR-1:0]       i_tmr_wdog,
   input  wire logic [NTMR-1:0]       i_tmr_restart,
   input  wire logic [TW_WIDE-1:0]    i_tmr0_reload,
   input  wire logic [PW_WIDE-1:0]    i_tmr0_pre,
   input  wire logic [TW_WIDE-1:0]    i_tmr1_reload,
   input  wire logic [PW_WIDE-1:0]    i_tmr1_pre,
   input  wire logic [TW_WDOG-1:0]    i_tmr2_reload,
   input  wire logic [PW_WDOG-1:0]    i_tmr2_div,
   output logic                       o_sysfail,
   input  wire logic                  i_mbx_req,
   input  wire logic                  i_mbx_lock,
   input  wire logic                  i_mbx_wr,
   input  wire logic [MSW-1:0]        i_mbx_sel,
   input  wire logic [VW-1:0]         i_mbx_wdata,
   output logic                       o_mbx_ack,
   output logic [VW-1:0]              o_mbx_rdata,
   input  wire logic [NMBX-1:0]       i_mbx_clr,
   output logic [NMBX-1:0]            o_mbx_pend,
   output logic [LW-1:0]              o_ipl,
   input  wire logic                  i_iack,
   input  wire logic [LW-1:0]         i_iack_lvl,
   output logic                       o_vec_valid,
   output logic [VW-1:0]              o_vec,
   output logic                       o_fetch_periph,
   output logic                       o_fetch_bus,
   output logic [SIW-1:0]             o_fetch_src,
   input  wire logic                  i_fetch_done,
   input  wire logic [VW-1:0]         i_fetch_vec,
   output logic [NSRC-1:0]            o_pending
);

   typedef enum {ST_IDLE, ST_FETCH} bih_ack_type;

   logic [SYW-1:0]    sync1_ff;
   logic [SYW-1:0]    sync2_ff;
   logic [NTMR-1:0]   tmr_pend_ff;
   logic [NMBX-1:0]   mbx_pend_ff;
   logic [VW-1:0]     mbx_mem [NMBX];
   logic              mbx_ack_ff;
   logic [VW-1:0]     mbx_rdata_ff;
   logic              lock_ff;
   logic [MSW-1:0]    lock_sel_ff;
   logic [LW-1:0]     ipl_ff;
   bih_ack_type       st_ff;
   logic              vec_valid_ff;
   logic [VW-1:0]     vec_ff;
   logic              fetch_p_ff;
   logic              fetch_b_ff;
   logic [SIW-1:0]    fetch_src_ff;
   logic [NTMR-1:0]   tmr_exp;
   logic [NTMR-1:0]   tmr_fail;
   logic [NSRC-1:0]   pend;
   logic [LW-1:0]     max_lvl;
   logic              hit;
   logic [SIW-1:0]    hit_idx;

   // every pin-side signal goes through two stages before use
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= {i_bus_irq, i_exp_irq, i_ser_irq, i_cal_irq, i_pfail, i_sfail_in,
                      i_loc_irq, i_mbx_req, i_mbx_lock, i_mbx_wr, i_mbx_sel, i_mbx_wdata};
         sync2_ff <= sync1_ff;
      end
   end

   bih_timer #(.W(TW_WIDE), .PW(PW_WIDE)) u_tmr0 (
      .i_clk     (i_clk),
      .i_nrst    (i_nrst),
      .i_en      (i_tmr_en[0]),
      .i_wdog    (i_tmr_wdog[0]),
      .i_restart (i_tmr_restart[0]),
      .i_reload  (i_tmr0_reload),
      .i_pre     (i_tmr0_pre),
      .o_expire  (tmr_exp[0]),
      .o_fail    (tmr_fail[0])
   );

   bih_timer #(.W(TW_WIDE), .PW(PW_WIDE)) u_tmr1 (
      .i_clk     (i_clk),
      .i_nrst    (i_nrst),
      .i_en      (i_tmr_en[1]),
      .i_wdog    (i_tmr_wdog[1]),
      .i_restart (i_tmr_restart[1]),
      .i_reload  (i_tmr1_reload),
      .i_pre     (i_tmr1_pre),
      .o_expire  (tmr_exp[1]),
      .o_fail    (tmr_fail[1])
   );

   bih_timer #(.W(TW_WDOG), .PW(PW_WDOG)) u_tmr2 (
      .i_clk     (i_clk),
      .i_nrst    (i_nrst),
      .i_en      (i_tmr_en[2]),
      .i_wdog    (i_tmr_wdog[2]),
      .i_restart (i_tmr_restart[2]),
      .i_reload  (i_tmr2_reload),
      .i_pre     (i_tmr2_div),
      .o_expire  (tmr_exp[2]),
      .o_fail    (tmr_fail[2])
   );

   assign o_sysfail = tmr_fail[2];

   // mailbox access: four-phase on the synchronised request
   wire [MSW-1:0] mbx_sel  = sync2_ff[SY_SEL +: MSW];
   wire           mbx_req  = sync2_ff[SY_REQ];
   wire           mbx_lock = sync2_ff[SY_LOCK];
   wire           mbx_ok   = !lock_ff || (lock_sel_ff == mbx_sel);
   wire           mbx_go   = mbx_req && !mbx_ack_ff && mbx_ok;

   // acknowledge decoding
   wire           ack_go    = (st_ff == ST_IDLE) && i_iack;
   wire           ack_take  = ack_go && hit;
   wire bih_vsrc_type hit_vs = bih_vsrc_of(hit_idx);
   wire           hit_mbx   = bih_is_mbx(hit_idx);
   wire [VW-1:0]  own_vec   = hit_mbx ? i_lvl_vec[i_iack_lvl*VW +: VW]
                                      : VW'(i_vec_base + {2'h0, hit_idx});
   wire [NTMR-1:0] tmr_ack  = ack_take ? NTMR'(1 << (hit_idx - 6'(SRC_TMR))) : '0;
   wire [NMBX-1:0] mbx_ack_clr = (ack_take && hit_mbx)
                                 ? NMBX'(1 << (hit_idx - 6'(SRC_MBX))) : '0;
   wire [NMBX-1:0] mbx_set  = mbx_go ? NMBX'(1 << mbx_sel) : '0;
   wire           tmr_hit   = hit_idx >= 6'(SRC_TMR) && hit_idx < 6'(SRC_PFAIL);

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         mbx_ack_ff   <= 1'b0;
         mbx_rdata_ff <= VEC_RST;
         lock_ff      <= 1'b0;
         lock_sel_ff  <= '0;
         mbx_pend_ff  <= '0;
         tmr_pend_ff  <= '0;
      end
      else
      begin
         mbx_ack_ff <= mbx_req && (mbx_ack_ff || mbx_ok);
         // lock holds the box across the cycle
         if (!mbx_lock)
            lock_ff <= 1'b0;
         else if (mbx_go)
            lock_ff <= 1'b1;
         if (mbx_go)
         begin
            lock_sel_ff  <= mbx_sel;
            mbx_rdata_ff <= mbx_mem[mbx_sel];
         end
         mbx_pend_ff <= (mbx_pend_ff & ~i_mbx_clr & ~mbx_ack_clr) | mbx_set;
         tmr_pend_ff <= (tmr_pend_ff & ~(tmr_hit ? tmr_ack : '0)) | tmr_exp;
      end
   end

   // mailbox contents are data only, reset is not needed
   always_ff @(posedge i_clk)
   begin
      if (mbx_go && sync2_ff[SY_WR])
         mbx_mem[mbx_sel] <= sync2_ff[SY_WDATA +: VW];
   end

   assign pend = {sync2_ff[SY_LOC +: NLOC], mbx_pend_ff, sync2_ff[SY_SFAIL],
                  sync2_ff[SY_PFAIL], tmr_pend_ff, sync2_ff[SY_CAL], sync2_ff[SY_SER],
                  sync2_ff[SY_EXP], sync2_ff[SY_BUS +: NBUSIRQ]};

   bih_prio #(.N(NSRC)) u_prio (
      .i_pend    (pend),
      .i_level   (i_src_level),
      .i_qlvl    (i_iack_lvl),
      .o_max_lvl (max_lvl),
      .o_hit     (hit),
      .o_idx     (hit_idx)
   );

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         st_ff        <= ST_IDLE;
         ipl_ff       <= LVL_OFF;
         vec_valid_ff <= 1'b0;
         vec_ff       <= VEC_RST;
         fetch_p_ff   <= 1'b0;
         fetch_b_ff   <= 1'b0;
         fetch_src_ff <= '0;
      end
      else
      begin
         ipl_ff       <= max_lvl;
         vec_valid_ff <= 1'b0;
         fetch_p_ff   <= 1'b0;
         fetch_b_ff   <= 1'b0;
         unique case (st_ff)
            ST_IDLE:
            begin
               if (ack_go && !hit)
               begin
                  vec_valid_ff <= 1'b1;
                  vec_ff       <= SPUR_VEC;
               end
               else if (ack_take && hit_vs == VS_OWN)
               begin
                  vec_valid_ff <= 1'b1;
                  vec_ff       <= own_vec;
               end
               else if (ack_take)
               begin
                  fetch_p_ff   <= (hit_vs == VS_PERIPH);
                  fetch_b_ff   <= (hit_vs == VS_BUS);
                  fetch_src_ff <= hit_idx;
                  st_ff        <= ST_FETCH;
               end
            end
            ST_FETCH:
               if (i_fetch_done)
               begin
                  vec_valid_ff <= 1'b1;
                  vec_ff       <= i_fetch_vec;
                  st_ff        <= ST_IDLE;
               end
         endcase
      end
   end

   assign o_mbx_ack      = mbx_ack_ff;
   assign o_mbx_rdata    = mbx_rdata_ff;
   assign o_mbx_pend     = mbx_pend_ff;
   assign o_ipl          = ipl_ff;
   assign o_vec_valid    = vec_valid_ff;
   assign o_vec          = vec_ff;
   assign o_fetch_periph = fetch_p_ff;
   assign o_fetch_bus    = fetch_b_ff;
   assign o_fetch_src    = fetch_src_ff;
   assign o_pending      = pend;

   ipl_max_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ##1 (o_ipl == $past(max_lvl)) && (o_ipl >= $past(i_src_level[SRC_EXP*LW +: LW])
           || !$past(pend[SRC_EXP])))
      else $error("presented level is not the highest pending");
   pick_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      hit |-> (pend[hit_idx] && i_src_level[hit_idx*LW +: LW] == i_iack_lvl))
      else $error("acknowledged source not at asked level");
   own_vec_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (ack_take && hit_vs == VS_OWN && !hit_mbx) |=>
      (o_vec_valid && o_vec == VW'($past(i_vec_base) + {2'h0, $past(hit_idx)})))
      else $error("own vector not base plus increment");
   fetch_bus_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (ack_take && hit_vs == VS_BUS) |=> (o_fetch_bus && !o_vec_valid && st_ff == ST_FETCH))
      else $error("bus source did not start a vector fetch");
   spur_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (ack_go && !hit) |=> (o_vec_valid && o_vec == SPUR_VEC))
      else $error("no spurious vector for empty level");
   mbx_raise_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      mbx_go |=> (o_mbx_ack && o_mbx_pend[$past(mbx_sel)]))
      else $error("mailbox access did not raise its interrupt");
   mbx_lock_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (lock_ff && mbx_req && !mbx_ack_ff && mbx_sel != lock_sel_ff) |=> !o_mbx_ack)
      else $error("locked mailbox cycle was broken");
   sysfail_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_sysfail |-> (i_tmr_wdog[2] || $past(i_tmr_wdog[2])))
      else $error("system-fail without watchdog mode");

   own_cov: cover property (@(posedge i_clk) disable iff (!i_nrst)
      ack_take && hit_vs == VS_OWN);
   fetch_cov: cover property (@(posedge i_clk) disable iff (!i_nrst)
      (st_ff == ST_FETCH) ##1 i_fetch_done);
   rmw_cov: cover property (@(posedge i_clk) disable iff (!i_nrst)
      lock_ff && mbx_go && sync2_ff[SY_WR]);
   sfail_cov: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_sysfail));

endmodule

// ===== bench/bih_cpu_model.sv
module bih_cpu_model
   import bih_pkg::*;
(
   input  wire logic           i_clk,
   input  wire logic           i_fetch_periph,
   input  wire logic           i_fetch_bus,
   input  wire logic [SIW-1:0] i_fetch_src,
   input  wire logic           i_slow,
   output logic                o_fetch_done,
   output logic [VW-1:0]       o_fetch_vec
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [VW-1:0] ans;
   initial
   begin
      o_fetch_done = 1'b0;
      o_fetch_vec  = 8'h5a;
      forever
      begin
         @(negedge i_clk);
         // undriven vector lines keep toggling so a stale value never matches
         o_fetch_vec = ~o_fetch_vec;
         if (i_fetch_periph === 1'b1 || i_fetch_bus === 1'b1)
         begin
            ans = (i_fetch_bus ? 8'hc0 : 8'h40) | VW'(i_fetch_src);
            repeat (i_slow ? 5 : 1)
            begin
               @(negedge i_clk);
               o_fetch_vec = ~o_fetch_vec;
            end
            o_fetch_done = 1'b1;
            o_fetch_vec  = ans;
            @(negedge i_clk);
            o_fetch_done = 1'b0;
            o_fetch_vec  = ~ans;
         end
      end
   end
endmodule

// ===== bench/bih_hub_tb.sv
module bih_hub_tb
   import bih_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [VW-1:0] SPUR = 8'h3c;
   logic               clk, nrst, exp_irq, ser_irq, cal_irq, pfail, sfail, sysfail;
   logic               req, lock, wr, ack, iack, vval, fper, fbus, fdone, slow;
   logic [NBUSIRQ-1:0] bus_irq;
   logic [NLOC-1:0]    loc_irq;
   logic [NSRC*LW-1:0] src_level;
   logic [VW-1:0]      vec_base, wdata, rdata, vec, fvec;
   logic [NLVL*VW-1:0] lvl_vec;
   logic [NTMR-1:0]    tmr_en, tmr_wdog, tmr_rst;
   logic [TW_WIDE-1:0] rl0, rl1;
   logic [PW_WIDE-1:0] pre0, pre1;
   logic [TW_WDOG-1:0] rl2;
   logic [PW_WDOG-1:0] div2;
   logic [MSW-1:0]     sel;
   logic [NMBX-1:0]    mclr, mpend;
   logic [LW-1:0]      ipl, ilvl;
   logic [SIW-1:0]     fsrc;
   logic [NSRC-1:0]    pend;
   logic [31:0]        rs;
   logic [VW-1:0]      mbox[NMBX];
   int                 num_errors, total_checks, cyc, k, l;
   int                 mlvl[NSRC];
   bit                 mpin[NSRC];
   int                 srcs[10] = '{0, 3, 6, 7, 8, 9, 13, 14, 23, 39};

   bih_hub #(.SPUR_VEC(SPUR)) i_dut (.i_clk(clk), .i_nrst(nrst), .i_bus_irq(bus_irq),
      .i_exp_irq(exp_irq), .i_ser_irq(ser_irq), .i_cal_irq(cal_irq), .i_pfail(pfail),
      .i_sfail_in(sfail), .i_loc_irq(loc_irq), .i_src_level(src_level), .i_vec_base(vec_base),
      .i_lvl_vec(lvl_vec), .i_tmr_en(tmr_en), .i_tmr_wdog(tmr_wdog), .i_tmr_restart(tmr_rst),
      .i_tmr0_reload(rl0), .i_tmr0_pre(pre0), .i_tmr1_reload(rl1), .i_tmr1_pre(pre1),
      .i_tmr2_reload(rl2), .i_tmr2_div(div2), .o_sysfail(sysfail), .i_mbx_req(req),
      .i_mbx_lock(lock), .i_mbx_wr(wr), .i_mbx_sel(sel), .i_mbx_wdata(wdata),
      .o_mbx_ack(ack), .o_mbx_rdata(rdata), .i_mbx_clr(mclr), .o_mbx_pend(mpend),
      .o_ipl(ipl), .i_iack(iack), .i_iack_lvl(ilvl), .o_vec_valid(vval), .o_vec(vec),
      .o_fetch_periph(fper), .o_fetch_bus(fbus), .o_fetch_src(fsrc),
      .i_fetch_done(fdone), .i_fetch_vec(fvec), .o_pending(pend));

   bih_cpu_model i_cpu (.i_clk(clk), .i_fetch_periph(fper), .i_fetch_bus(fbus),
      .i_fetch_src(fsrc), .i_slow(slow), .o_fetch_done(fdone), .o_fetch_vec(fvec));

   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   // model: highest level among pending sources, lowest index wins a tie
   function automatic int m_ipl();
      int m = 0;
      for (int i = 0; i < NSRC; i++)
         if (mpin[i] && mlvl[i] > m)
            m = mlvl[i];
      return m;
   endfunction

   function automatic int m_pick(int lv);
      for (int i = 0; i < NSRC; i++)
         if (mpin[i] && mlvl[i] == lv)
            return i;
      return -1;
   endfunction

   task automatic check(string nm, logic [63:0] seen, logic [63:0] ex);
      total_checks++;
      if (seen !== ex)
      begin
         num_errors++;
         $display("ERROR %s expected %0h seen %0h", nm, ex, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wcyc(int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic set_lvl(int i, int lv);
      src_level[i*LW +: LW] = LW'(lv);
      mlvl[i] = lv;
   endtask

   task automatic pin(int i, logic v);
      mpin[i] = v;
      if (i < SRC_EXP) bus_irq[i] = v;
      else if (i == SRC_EXP) exp_irq = v;
      else if (i == SRC_SER) ser_irq = v;
      else if (i == SRC_CAL) cal_irq = v;
      else if (i == SRC_PFAIL) pfail = v;
      else if (i == SRC_SFAIL) sfail = v;
      else if (i >= SRC_LOC) loc_irq[i-SRC_LOC] = v;
   endtask

   task automatic do_iack(int lv, output int kk);
      int n;
      logic [VW-1:0] ev;
      kk = m_pick(lv);
      @(negedge clk);
      iack = 1'b1;
      ilvl = LW'(lv);
      @(negedge clk);
      iack = 1'b0;
      if (kk < 0) ev = SPUR;
      else if (kk >= SRC_MBX && kk < SRC_LOC) ev = lvl_vec[lv*VW +: VW];
      else ev = vec_base + VW'(kk);
      if (kk >= 0 && (kk <= SRC_EXP || kk == SRC_SER || kk >= SRC_LOC))
      begin
         for (n = 0; n < 10 && fper !== 1'b1 && fbus !== 1'b1; n++) @(negedge clk);
         check("fetch_kind", {fbus, fper}, (kk <= SRC_EXP) ? 2 : 1);
         check("fetch_src", fsrc, kk);
         ev = ((kk <= SRC_EXP) ? 8'hc0 : 8'h40) | VW'(kk);
      end
      for (n = 0; n < 20 && vval !== 1'b1; n++) @(negedge clk);
      check("vec", vec, ev);
      if (kk >= SRC_TMR && kk < SRC_LOC && kk != SRC_PFAIL && kk != SRC_SFAIL) mpin[kk] = 0;
   endtask

   task automatic mbx(int s, logic w, logic lk, logic [VW-1:0] d, logic ck);
      int n;
      @(negedge clk);
      sel = MSW'(s);
      wr = w;
      wdata = d;
      lock = lk;
      req = 1'b1;
      for (n = 0; n < 10 && ack !== 1'b1; n++) @(negedge clk);
      check("mbx_ack", ack, 1);
      if (ck) check("mbx_rdata", rdata, mbox[s]);
      if (w) mbox[s] = d;
      mpin[SRC_MBX+s] = 1;
      req = 1'b0;
      for (n = 0; n < 10 && ack !== 1'b0; n++) @(negedge clk);
   endtask

   task automatic tmr_period(int t, int per);
      int t0, n;
      set_lvl(SRC_TMR+t, 4);
      tmr_en[t] = 1'b1;
      for (n = 0; n < 200 && pend[SRC_TMR+t] !== 1'b1; n++) @(negedge clk);
      t0 = cyc;
      mpin[SRC_TMR+t] = 1;
      wcyc(2);
      check("tmr_ipl", ipl, 4);
      do_iack(4, k);
      for (n = 0; n < 200 && pend[SRC_TMR+t] !== 1'b1; n++) @(negedge clk);
      check("tmr_period", cyc - t0, per);
      tmr_en[t] = 1'b0;
      set_lvl(SRC_TMR+t, 0);
      mpin[SRC_TMR+t] = 0;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 6000)
      begin
         num_errors++;
         finish_test();
      end
   end

   initial
   begin
      {nrst, exp_irq, ser_irq, cal_irq, pfail, sfail, req, lock, wr, iack, slow} = '0;
      {bus_irq, loc_irq, src_level, tmr_en, tmr_wdog, tmr_rst, sel, mclr, ilvl} = '0;
      {rl0, rl1, pre0, pre1, rl2, div2, wdata} = '0;
      rs = 32'h32a4;
      vec_base = 8'h20;
      for (int i = 0; i < NLVL; i++) lvl_vec[i*VW +: VW] = 8'ha0 + VW'(i);
      repeat (4) @(negedge clk);
      check("rst_out", {ipl, vval, ack, sysfail, fper, fbus, mpend, pend}, 0);
      check("rst_data", {vec, rdata, fsrc}, 0);
      nrst = 1'b1;
      wcyc(2);
      $display("test reset done");
      foreach (srcs[i])
      begin
         l = int'(xs() % 7) + 1;
         slow = srcs[i][0];
         set_lvl(srcs[i], l);
         pin(srcs[i], 1'b1);
         wcyc(5);
         check("ipl", ipl, l);
         do_iack(l, k);
         pin(srcs[i], 1'b0);
         wcyc(5);
         check("ipl_idle", ipl, 0);
      end
      $display("test sources done");
      set_lvl(SRC_CAL, 2);
      set_lvl(SRC_PFAIL, 5);
      set_lvl(SRC_SFAIL, 5);
      set_lvl(25, 0);
      foreach (srcs[i]) if (srcs[i] > SRC_CAL && srcs[i] < SRC_LOC) pin(srcs[i], 1'b1);
      pin(SRC_CAL, 1'b1);
      pin(25, 1'b1);
      wcyc(5);
      repeat (3)
      begin
         check("ipl_prio", ipl, m_ipl());
         do_iack(m_ipl(), k);
         pin(k, 1'b0);
         wcyc(5);
      end
      check("ipl_off", ipl, 0);
      check("raw_pend", pend[25], 1);
      do_iack(3, k);
      pin(25, 1'b0);
      $display("test priority done");
      for (int s = 0; s < NMBX; s += 7)
      begin
         l = int'(xs() % 7) + 1;
         set_lvl(SRC_MBX+s, l);
         mbx(s, 1'b1, 1'b0, VW'(xs()), 1'b0);
         mbx(s, 1'b0, 1'b1, 8'h00, 1'b1);
         mbx(s, 1'b1, 1'b1, VW'(xs()), 1'b1);
         // another box is held off while the lock stands
         @(negedge clk);
         sel = MSW'(s ^ 1);
         wr = 1'b0;
         req = 1'b1;
         wcyc(6);
         check("mbx_refused", ack, 0);
         lock = 1'b0;
         for (int n = 0; n < 10 && ack !== 1'b1; n++) @(negedge clk);
         check("mbx_unlock", ack, 1);
         req = 1'b0;
         for (int n = 0; n < 10 && ack !== 1'b0; n++) @(negedge clk);
         wcyc(3);
         check("mbx_pend", mpend[s], 1);
         check("mbx_ipl", ipl, l);
         do_iack(l, k);
         wcyc(2);
         check("mbx_taken", mpend[s], 0);
         mbx(s, 1'b1, 1'b0, VW'(xs()), 1'b1);
         mclr[s] = 1'b1;
         @(negedge clk);
         mclr[s] = 1'b0;
         mpin[SRC_MBX+s] = 0;
         wcyc(3);
         check("mbx_clr", mpend[s], 0);
         set_lvl(SRC_MBX+s, 0);
      end
      $display("test mailbox done");
      pre0 = 5'h1f;
      tmr_period(0, 32);
      rl1 = 24'h000009;
      tmr_period(1, 10);
      rl2 = 8'h03;
      div2 = 4'h1;
      tmr_wdog[2] = 1'b1;
      tmr_en[2] = 1'b1;
      // restart with the enable so the zeroed counter cannot expire at once
      tmr_rst[2] = 1'b1;
      repeat (10)
      begin
         @(negedge clk);
         tmr_rst[2] = 1'b1;
         @(negedge clk);
         tmr_rst[2] = 1'b0;
         wcyc(2);
         check("wdog_kept", sysfail, 0);
      end
      for (int n = 0; n < 30 && sysfail !== 1'b1; n++) @(negedge clk);
      check("wdog_fail", sysfail, 1);
      // the pending bit follows the expiry pulse one cycle after the fail
      @(negedge clk);
      check("wdog_pend", pend[SRC_TMR+2], 1);
      tmr_rst[2] = 1'b1;
      @(negedge clk);
      tmr_rst[2] = 1'b0;
      tmr_wdog[2] = 1'b0;
      wcyc(40);
      check("periodic_nofail", sysfail, 0);
      $display("test timers done");
      finish_test();
   end
endmodule
